// File: src/isr_status.v
// Status byte, service request and standard event logic plus the cyclic
// error queue of an instrument's remote interface.
// Assumes a command parser and output queue on the same clock, which give
// one-cycle strobes for commands and events and a level for pending output.
`timescale 1ns/100ps
`include "isr_status_regs.vh"

// Notes on behaviour
// - Status bit 2 is high whenever the error queue holds an entry.
// - Status bit 4 is high while response data waits to be read.
// - Status bit 5 is high when any enabled standard event is set.
// - Request-service bit 6 set when any status bit meets its enable bit.
// - Status bits 0, 1, 3 and 7 always read zero.
// - Serial poll returns the status byte then clears request-service.
// - Eight-bit service request mask aligned with status byte bits.
// - Standard event bit 0 set when operation-complete command executes.
// - Event bit 2 set on read with no response or lost response.
// - Event bit 3 set when an internal device condition fails an operation.
// - Event bit 4 set when a valid command cannot be carried out.
// - Event bit 5 set on syntax error; a code -199..-100 is queued.
// - Event bit 7 set at power-on; bits 1 and 6 never set.
// - Eight-bit standard event mask; only enabled events reach the summary.
// - Error codes are kept in a cyclic queue of ten entries.
// - Each queue read returns oldest code with description, then removes it.
// - Beyond nine unread errors, excess is dropped and -350 recorded.
// - Execution codes: -211 trigger ignored, -221 conflict, -222 range.
// - Query codes -410, -420; deadlock logs -430, flushes, waits for END.
// - System codes: 401 at power-on, 402 after operation complete.
// - Device codes: -315 configuration lost, -330 self-test failed.
// - Suffix over 12 chars, exponent over 32000, over 255 digits are errors.
// - Reading the standard event register returns it and clears it.
// - Bit 6 of the service request mask is ignored and stays zero.
// - Status query does not clear request-service; it follows its cause.
module isr_status
(
    input  wire        clock_in,
    input  wire        srst_in,
    input  wire        sre_wr_in,
    input  wire [7:0]  sre_data_in,
    input  wire        ese_wr_in,
    input  wire [7:0]  ese_data_in,
    input  wire        esr_rd_in,
    input  wire        cls_in,
    input  wire        serial_poll_in,
    input  wire        resp_pending_in,
    input  wire        ctrl_read_in,
    input  wire        resp_lost_in,
    input  wire        deadlock_in,
    input  wire        end_msg_in,
    input  wire        opc_exec_in,
    input  wire        syntax_err_in,
    input  wire [15:0] syntax_code_in,
    input  wire        num_chk_in,
    input  wire [7:0]  suffix_len_in,
    input  wire [15:0] exp_mag_in,
    input  wire [9:0]  digit_cnt_in,
    input  wire        trig_ignored_in,
    input  wire        conflict_in,
    input  wire        range_err_in,
    input  wire        cfg_lost_in,
    input  wire        selftest_fail_in,
    input  wire        eq_read_in,
    output reg  [7:0]  stb_query_out,
    output reg  [7:0]  poll_byte_out,
    output reg         srq_out,
    output reg  [7:0]  sre_out,
    output reg  [7:0]  ese_out,
    output reg  [7:0]  esr_data_out,
    output reg         eq_valid_out,
    output reg  [15:0] eq_code_out,
    output reg  [2:0]  eq_desc_out,
    output reg         flush_bufs_out,
    output reg         skip_to_end_out
);

    // Description class of a code; also picks the event bit it sets
    function [2:0] isr_class;
        input [15:0] code;
        begin
            if ($signed(code) >= $signed(`ISR_CODE_CMD_LO)
                && $signed(code) <= $signed(`ISR_CODE_CMD))
                isr_class = `ISR_DESC_CMD;
            else if ($signed(code) >= $signed(`ISR_CODE_EXE_LO)
                && $signed(code) < $signed(`ISR_CODE_CMD_LO))
                isr_class = `ISR_DESC_EXE;
            else if ($signed(code) >= $signed(`ISR_CODE_DDE_LO)
                && $signed(code) < $signed(`ISR_CODE_EXE_LO))
                isr_class = `ISR_DESC_DDE;
            else if ($signed(code) >= $signed(`ISR_CODE_QYE_LO)
                && $signed(code) < $signed(`ISR_CODE_DDE_LO))
                isr_class = `ISR_DESC_QYE;
            else if ($signed(code) > $signed(`ISR_CODE_NONE))
                isr_class = `ISR_DESC_SYS;
            else
                isr_class = `ISR_DESC_NONE;
        end
    endfunction

    // Cyclic pointer step over the ten slots
    function [3:0] isr_step;
        input [3:0] ptr;
        begin
            if (ptr == `ISR_EQ_LAST)
                isr_step = `ISR_EQ_ZERO;
            else
                isr_step = ptr + `ISR_EQ_ONE;
        end
    endfunction

    // Queue slots, pointers and the programmable masks and flags
    reg  [15:0] eq_mem [0:`ISR_EQ_LAST];
    reg  [3:0]  eq_wp;
    reg  [3:0]  eq_rp;
    reg  [3:0]  eq_count;
    reg  [7:0]  service_request_mask;
    reg  [7:0]  ese;
    reg  [7:0]  esr;
    reg         rqs;
    reg         srq_prev;
    reg         pon_pend;

    // Combinational terms settled once per cycle
    reg         push;
    reg  [15:0] push_code;
    reg  [7:0]  set_bits;
    reg         pop;
    reg         store;
    reg  [15:0] store_code;
    reg  [3:0]  space;
    reg  [3:0]  next_wp;
    reg  [3:0]  next_rp;
    reg  [3:0]  next_count;
    reg  [7:0]  stb_now;
    reg         srq_now;

    wire        early_read = ctrl_read_in & ~resp_pending_in;
    wire        exp_big    = num_chk_in && (exp_mag_in > `ISR_MAX_EXP);
    wire        digits_big = num_chk_in && (digit_cnt_in > `ISR_MAX_DIGITS);
    wire        suffix_big = num_chk_in && (suffix_len_in > `ISR_MAX_SUFFIX);
    wire [15:0] syn_code   = (isr_class(syntax_code_in) == `ISR_DESC_CMD)
                             ? syntax_code_in : `ISR_CODE_CMD;

    // Event collection; one code per cycle, the most urgent source wins
    // the queue slot while every source still marks its event class.
    // A single queue write port keeps the store logic small.
    always @*
    begin
        push_code = `ISR_CODE_NONE;
        set_bits  = `ISR_BYTE_ZERO;
        set_bits[`ISR_SE_PON] = pon_pend;
        set_bits[`ISR_SE_OPC] = opc_exec_in;
        // query problems outrank the rest
        // since they also disturb the message exchange itself
        if (deadlock_in)
            push_code = `ISR_CODE_DEADLOCK;
        else if (resp_lost_in)
            push_code = `ISR_CODE_INTERRUPT;
        else if (early_read)
            push_code = `ISR_CODE_EARLY_RD;
        // numeric limits, checked with the number's
        // length and exponent strobed together
        else if (exp_big)
            push_code = `ISR_CODE_EXP_BIG;
        else if (digits_big)
            push_code = `ISR_CODE_DIGITS;
        else if (suffix_big)
            push_code = `ISR_CODE_SUFFIX;
        // syntax errors kept inside the command range
        // a stray code from the parser becomes the generic one
        else if (syntax_err_in)
            push_code = syn_code;
        // execution failures
        // trigger first as it is tied to a bus command
        else if (trig_ignored_in)
            push_code = `ISR_CODE_TRIG_IGN;
        else if (conflict_in)
            push_code = `ISR_CODE_CONFLICT;
        else if (range_err_in)
            push_code = `ISR_CODE_RANGE;
        // device failures
        // lost configuration before a failed self-test
        else if (cfg_lost_in)
            push_code = `ISR_CODE_CFG_LOST;
        else if (selftest_fail_in)
            push_code = `ISR_CODE_SELFTEST;
        // system codes last; an error in the first cycle
        // after reset takes the slot of the power-on code
        else if (opc_exec_in)
            push_code = `ISR_CODE_OPC_DONE;
        else if (pon_pend)
            push_code = `ISR_CODE_POWER_ON;
        // Every code in use is non-zero,
        // so a zero code means nothing to queue
        push = (push_code != `ISR_CODE_NONE);
        // class bit from the winning code
        case (isr_class(push_code))
            `ISR_DESC_CMD: set_bits[`ISR_SE_CME] = 1'b1;
            `ISR_DESC_EXE: set_bits[`ISR_SE_EXE] = 1'b1;
            `ISR_DESC_DDE: set_bits[`ISR_SE_DDE] = 1'b1;
            `ISR_DESC_QYE: set_bits[`ISR_SE_QYE] = 1'b1;
            default:       set_bits[`ISR_SE_OPC] = set_bits[`ISR_SE_OPC];
        endcase
        // Losing events still mark their class; only the code is dropped
        if (syntax_err_in | num_chk_in & (exp_big | digits_big | suffix_big))
            set_bits[`ISR_SE_CME] = 1'b1;
        if (trig_ignored_in | conflict_in | range_err_in)
            set_bits[`ISR_SE_EXE] = 1'b1;
        if (cfg_lost_in | selftest_fail_in)
            set_bits[`ISR_SE_DDE] = 1'b1;
        if (early_read | resp_lost_in | deadlock_in)
            set_bits[`ISR_SE_QYE] = 1'b1;
    end

    // Queue bookkeeping; capacity judged after this cycle's read
    always @*
    begin
        // empty read leaves the queue alone
        pop        = eq_read_in && (eq_count != `ISR_EQ_ZERO) && !cls_in;
        space      = cls_in ? `ISR_EQ_ZERO : (eq_count - {3'h0, pop});
        store      = 1'b0;
        store_code = push_code;
        // last free slot takes the overflow code, excess dropped
        if (push && space < `ISR_EQ_LAST)
            store = 1'b1;
        else if (push && space == `ISR_EQ_LAST)
        begin
            store      = 1'b1;
            store_code = `ISR_CODE_OVERFLOW;
        end
        next_wp    = cls_in ? `ISR_EQ_ZERO : eq_wp;
        next_rp    = cls_in ? `ISR_EQ_ZERO : (pop ? isr_step(eq_rp) : eq_rp);
        next_count = space + {3'h0, store};
        if (store)
            next_wp = isr_step(next_wp);
    end

    // Status byte as the query sees it
    always @*
    begin
        stb_now = `ISR_BYTE_ZERO;
        stb_now[`ISR_STB_EVQ] = (eq_count != `ISR_EQ_ZERO);
        stb_now[`ISR_STB_MAV] = resp_pending_in;
        stb_now[`ISR_STB_ESB] = |(esr & ese);
        // any summary bit meeting its enable
        srq_now = |(stb_now & service_request_mask & `ISR_STB_SUMMARY);
        // query copy tracks the cause, other bits stay zero
        stb_now[`ISR_STB_RQS] = srq_now;
    end

    // Queue storage; no reset needed, pointers guard the contents
    always @(posedge clock_in)
    begin
        if (store)
            eq_mem[cls_in ? `ISR_EQ_ZERO : eq_wp] <= store_code;
    end

    // Control registers and queue pointers
    always @(posedge clock_in)
    begin
        if (srst_in)
        begin
            service_request_mask      <= `ISR_BYTE_ZERO;
            ese      <= `ISR_BYTE_ZERO;
            esr      <= `ISR_BYTE_ZERO;
            rqs      <= 1'b0;
            srq_prev <= 1'b0;
            pon_pend <= 1'b1;
            eq_wp    <= `ISR_EQ_ZERO;
            eq_rp    <= `ISR_EQ_ZERO;
            eq_count <= `ISR_EQ_ZERO;
        end
        else
        begin
            pon_pend <= 1'b0;
            eq_wp    <= next_wp;
            eq_rp    <= next_rp;
            eq_count <= next_count;
            srq_prev <= srq_now;
            // service mask, bit 6 forced low
            if (sre_wr_in)
                service_request_mask <= sre_data_in & `ISR_SRE_KEEP;
            if (ese_wr_in)
                ese <= ese_data_in;
            // read or clear-status empties flags; new events win
            if (esr_rd_in | cls_in)
                esr <= set_bits;
            else
                esr <= esr | set_bits;
            // poll clears request-service; a fresh cause wins
            if (srq_now & ~srq_prev)
                rqs <= 1'b1;
            else if (serial_poll_in)
                rqs <= 1'b0;
        end
    end

    // Registered outputs
    always @(posedge clock_in)
    begin
        if (srst_in)
        begin
            stb_query_out   <= `ISR_BYTE_ZERO;
            poll_byte_out   <= `ISR_BYTE_ZERO;
            srq_out         <= 1'b0;
            sre_out         <= `ISR_BYTE_ZERO;
            ese_out         <= `ISR_BYTE_ZERO;
            esr_data_out    <= `ISR_BYTE_ZERO;
            eq_valid_out    <= 1'b0;
            eq_code_out     <= `ISR_CODE_NONE;
            eq_desc_out     <= `ISR_DESC_NONE;
            flush_bufs_out  <= 1'b0;
            skip_to_end_out <= 1'b0;
        end
        else
        begin
            stb_query_out <= stb_now;
            srq_out       <= rqs;
            sre_out       <= service_request_mask;
            ese_out       <= ese;
            // poll byte carries the latched request-service bit
            if (serial_poll_in)
                poll_byte_out <= {stb_now[7], rqs, stb_now[5:0]};
            // value handed over in the cycle it is cleared
            if (esr_rd_in)
                esr_data_out <= esr;
            // oldest code or zero with its class
            eq_valid_out <= eq_read_in;
            if (eq_read_in)
            begin
                eq_code_out <= pop ? eq_mem[eq_rp] : `ISR_CODE_NONE;
                eq_desc_out <= pop ? isr_class(eq_mem[eq_rp]) : `ISR_DESC_NONE;
            end
            // deadlock flushes both buffers, parsing waits for END
            flush_bufs_out <= deadlock_in;
            if (deadlock_in)
                skip_to_end_out <= 1'b1;
            else if (end_msg_in)
                skip_to_end_out <= 1'b0;
        end
    end

endmodule // isr_status

// File: src/isr_status_regs.vh
// Constants for the status reporting block: bit positions, error codes,
// queue depth and numeric parser limits. Definitions only.
`ifndef ISR_STATUS_REGS_VH
`define ISR_STATUS_REGS_VH

// Status byte bit positions
`define ISR_STB_EVQ        2
`define ISR_STB_MAV        4
`define ISR_STB_ESB        5
`define ISR_STB_RQS        6

// Standard event bit positions
`define ISR_SE_OPC         0
`define ISR_SE_QYE         2
`define ISR_SE_DDE         3
`define ISR_SE_EXE         4
`define ISR_SE_CME         5
`define ISR_SE_PON         7

// Reset values and masks
`define ISR_BYTE_ZERO      8'h00
`define ISR_SRE_KEEP       8'hBF
`define ISR_STB_SUMMARY    8'h34

// Error queue geometry
`define ISR_EQ_DEPTH       4'hA
`define ISR_EQ_LAST        4'h9
`define ISR_EQ_ZERO        4'h0
`define ISR_EQ_ONE         4'h1

// Error codes, 16-bit two's complement
`define ISR_CODE_NONE      16'h0000
`define ISR_CODE_CMD       16'hFF9C
`define ISR_CODE_CMD_LO    16'hFF39
`define ISR_CODE_EXP_BIG   16'hFF85
`define ISR_CODE_DIGITS    16'hFF84
`define ISR_CODE_SUFFIX    16'hFF7A
`define ISR_CODE_EXE_LO    16'hFED5
`define ISR_CODE_TRIG_IGN  16'hFF2D
`define ISR_CODE_CONFLICT  16'hFF23
`define ISR_CODE_RANGE     16'hFF22
`define ISR_CODE_DDE_LO    16'hFE71
`define ISR_CODE_CFG_LOST  16'hFEC5
`define ISR_CODE_SELFTEST  16'hFEB6
`define ISR_CODE_OVERFLOW  16'hFEA2
`define ISR_CODE_QYE_LO    16'hFE0D
`define ISR_CODE_INTERRUPT 16'hFE66
`define ISR_CODE_EARLY_RD  16'hFE5C
`define ISR_CODE_DEADLOCK  16'hFE52
`define ISR_CODE_POWER_ON  16'h0191
`define ISR_CODE_OPC_DONE  16'h0192

// Description classes returned with each code
`define ISR_DESC_NONE      3'h0
`define ISR_DESC_CMD       3'h1
`define ISR_DESC_EXE       3'h2
`define ISR_DESC_DDE       3'h3
`define ISR_DESC_QYE       3'h4
`define ISR_DESC_SYS       3'h5

// Numeric parser limits
`define ISR_MAX_SUFFIX     8'h0C
`define ISR_MAX_EXP        16'h7D00
`define ISR_MAX_DIGITS     10'h0FF

`endif

// File: verification/isr_host_model.sv
// Bus controller model: serial polls and read requests to the block.
// Assumes the block takes a request at the edge where it is high.
`timescale 1ns/100ps
module isr_host_model
(
    input  wire clock_in,
    output wire serial_poll_out,
    output wire eq_read_out,
    output wire esr_rd_out,
    output wire ctrl_read_out
);
    reg [3:0] req_q = 4'h0;

    assign serial_poll_out = req_q[0];
    assign eq_read_out     = req_q[1];
    assign esr_rd_out      = req_q[2];
    assign ctrl_read_out   = req_q[3];

    // One-cycle strobe; the answer is settled just after the next edge
    task request(input [3:0] m);
        begin
            @(posedge clock_in) req_q <= m;
            @(posedge clock_in) req_q <= 4'h0;
            #1;
        end
    endtask
endmodule // isr_host_model

// File: verification/isr_status_asserts.sv
// Port-level checks of the status reporting block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module isr_status_asserts
(
    input wire        clock_in,
    input wire        srst_in,
    input wire        sre_wr_in,
    input wire [7:0]  sre_data_in,
    input wire        serial_poll_in,
    input wire        resp_pending_in,
    input wire        deadlock_in,
    input wire        end_msg_in,
    input wire        eq_read_in,
    input wire [7:0]  stb_query_out,
    input wire        srq_out,
    input wire [7:0]  sre_out,
    input wire [7:0]  esr_data_out,
    input wire        eq_valid_out,
    input wire [15:0] eq_code_out,
    input wire        flush_bufs_out,
    input wire        skip_to_end_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (srst_in);

    // Status byte, mask and event fields that never rise, and the mask write
    AST_STB_ZERO: assert property (
        stb_query_out[7] == 1'b0 && stb_query_out[3] == 1'b0 && stb_query_out[1:0] == 2'h0)
        else $error("unused status bit set");
    AST_SRE_BIT6: assert property (
        sre_out[6] == 1'b0) else $error("service mask bit 6 set");
    AST_ESR_UNUSED: assert property (
        esr_data_out[6] == 1'b0 && esr_data_out[1] == 1'b0) else $error("unused event bit");
    AST_SRE_WR: assert property (
        sre_wr_in |-> ##2 sre_out == ($past(sre_data_in, 2) & 8'hBF)) else $error("mask write lost");

    // Message-available follows a steady pending level
    AST_MAV: assert property (
        $past(resp_pending_in) == $past(resp_pending_in, 2) |-> stb_query_out[4] == $past(resp_pending_in))
        else $error("message available wrong");

    // A poll while the cause persists leaves the request line low
    AST_POLL_CLR: assert property (
        serial_poll_in && stb_query_out[6] && $past(stb_query_out[6]) ##1 stb_query_out[6] [*2]
        |-> !srq_out) else $error("request not cleared by poll");

    // Queue read answered exactly one cycle later
    AST_EQ_ANSWER: assert property (
        eq_read_in |=> eq_valid_out) else $error("queue read not answered");
    AST_EQ_CAUSE: assert property (
        eq_valid_out |-> $past(eq_read_in)) else $error("queue answer without read");

    // Deadlock flush pulse and discard until end of message
    AST_DL_PULSE: assert property (
        deadlock_in ##1 !deadlock_in |-> flush_bufs_out && skip_to_end_out ##1 !flush_bufs_out)
        else $error("deadlock flush wrong");
    AST_SKIP_HOLD: assert property (
        skip_to_end_out && !end_msg_in |=> skip_to_end_out) else $error("discard dropped early");
    AST_SKIP_END: assert property (
        end_msg_in && !deadlock_in |=> !skip_to_end_out) else $error("discard held past end");

    // Main scenarios reached
    cover property (eq_valid_out && eq_code_out == 16'hFEA2);
    cover property (serial_poll_in && srq_out);
    cover property (flush_bufs_out);
endmodule // isr_status_asserts

bind isr_status isr_status_asserts u_isr_status_asserts (
    .clock_in        (clock_in),
    .srst_in         (srst_in),
    .sre_wr_in       (sre_wr_in),
    .sre_data_in     (sre_data_in),
    .serial_poll_in  (serial_poll_in),
    .resp_pending_in (resp_pending_in),
    .deadlock_in     (deadlock_in),
    .end_msg_in      (end_msg_in),
    .eq_read_in      (eq_read_in),
    .stb_query_out   (stb_query_out),
    .srq_out         (srq_out),
    .sre_out         (sre_out),
    .esr_data_out    (esr_data_out),
    .eq_valid_out    (eq_valid_out),
    .eq_code_out     (eq_code_out),
    .flush_bufs_out  (flush_bufs_out),
    .skip_to_end_out (skip_to_end_out)
);

// File: verification/tb_top.sv
// Self-checking bench for the status reporting block.
// Assumes the host model drives the controller strobes.
`timescale 1ns/100ps
module tb_top;
    localparam [3:0] POLL = 4'h1, RD_EQ = 4'h2, RD_ESR = 4'h4, RD_CTRL = 4'h8;
    reg         clock_in   = 1'b0;
    reg         srst_in    = 1'b1;
    reg  [13:0] ev         = 14'h0000;
    reg  [7:0]  sre_data   = 8'h00;
    reg  [7:0]  ese_data   = 8'h00;
    reg  [15:0] syn_code   = 16'h0000;
    reg  [7:0]  suffix_len = 8'h00;
    reg  [15:0] exp_mag    = 16'h0000;
    reg  [9:0]  digits     = 10'h000;
    reg         pending    = 1'b0;
    wire        poll, eq_rd, esr_rd, ctrl_rd, srq, eq_valid, flush, skip;
    wire [7:0]  stb, poll_byte, sre_q, ese_q, esr_q;
    wire [15:0] eq_code;
    wire [2:0]  eq_desc;
    integer     fail_count = 0, n_tests = 0, cyc = 0, i;

    // 40 MHz clock
    initial forever #12.5 clock_in = ~clock_in;

    isr_host_model u_isr_host_model (.clock_in(clock_in), .serial_poll_out(poll),
        .eq_read_out(eq_rd), .esr_rd_out(esr_rd), .ctrl_read_out(ctrl_rd));

    isr_status u_isr_status (.clock_in(clock_in), .srst_in(srst_in), .sre_wr_in(ev[12]),
        .sre_data_in(sre_data), .ese_wr_in(ev[13]), .ese_data_in(ese_data), .esr_rd_in(esr_rd),
        .cls_in(ev[11]), .serial_poll_in(poll), .resp_pending_in(pending),
        .ctrl_read_in(ctrl_rd), .resp_lost_in(ev[8]), .deadlock_in(ev[9]), .end_msg_in(ev[10]),
        .opc_exec_in(ev[0]), .syntax_err_in(ev[1]), .syntax_code_in(syn_code),
        .num_chk_in(ev[2]), .suffix_len_in(suffix_len), .exp_mag_in(exp_mag),
        .digit_cnt_in(digits), .trig_ignored_in(ev[3]), .conflict_in(ev[4]),
        .range_err_in(ev[5]), .cfg_lost_in(ev[6]), .selftest_fail_in(ev[7]), .eq_read_in(eq_rd),
        .stb_query_out(stb), .poll_byte_out(poll_byte), .srq_out(srq), .sre_out(sre_q),
        .ese_out(ese_q), .esr_data_out(esr_q), .eq_valid_out(eq_valid), .eq_code_out(eq_code),
        .eq_desc_out(eq_desc), .flush_bufs_out(flush), .skip_to_end_out(skip));

    task check(input [15:0] seen, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp)
            begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    // Pulse strobes for one cycle, then let status bits settle
    task fire(input [13:0] m);
        begin
            @(posedge clock_in) ev <= m;
            @(posedge clock_in) ev <= 14'h0000;
            repeat (3) @(posedge clock_in);
            #1;
        end
    endtask

    // Raise events, pop one code, then read and clear the event flags
    task try(input [13:0] m, input [15:0] code, input [2:0] desc, input [7:0] flags);
        begin
            fire(m);
            u_isr_host_model.request(RD_EQ);
            check(eq_valid, 1'b1);
            check(eq_code, code);
            check(eq_desc, desc);
            u_isr_host_model.request(RD_ESR);
            check(esr_q, flags);
        end
    endtask

    task end_sim;
        begin
            $display("checks %0d mismatches %0d", n_tests, fail_count);
            if (fail_count == 0 && n_tests > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    // Hang guard; the tests need well under a thousand cycles
    always @(posedge clock_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            fail_count = fail_count + 1;
            end_sim;
        end
    end

    initial
    begin
        repeat (5) @(posedge clock_in);
        srst_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        #1;
        check(sre_q, 8'h00);
        check(ese_q, 8'h00);
        check(stb, 8'h04);
        try(14'h0000, 16'h0191, 3'h5, 8'h80);
        try(14'h0000, 16'h0000, 3'h0, 8'h00);
        check(stb, 8'h00);
        $display("test power_on done");
        // Every event source with its code, class and flag
        try(14'h0001, 16'h0192, 3'h5, 8'h01);
        try(14'h0008, 16'hFF2D, 3'h2, 8'h10);
        try(14'h0010, 16'hFF23, 3'h2, 8'h10);
        try(14'h0020, 16'hFF22, 3'h2, 8'h10);
        try(14'h0040, 16'hFEC5, 3'h3, 8'h08);
        try(14'h0080, 16'hFEB6, 3'h3, 8'h08);
        try(14'h0100, 16'hFE66, 3'h4, 8'h04);
        @(posedge clock_in) syn_code <= 16'hFF8F;
        try(14'h0002, 16'hFF8F, 3'h1, 8'h20);
        @(posedge clock_in) syn_code <= 16'h0005;
        try(14'h0002, 16'hFF9C, 3'h1, 8'h20);
        @(posedge clock_in) {suffix_len, exp_mag, digits} <= {8'h0C, 16'h7D00, 10'h0FF};
        try(14'h0004, 16'h0000, 3'h0, 8'h00);
        @(posedge clock_in) suffix_len <= 8'h0D;
        try(14'h0004, 16'hFF7A, 3'h1, 8'h20);
        @(posedge clock_in) {suffix_len, exp_mag} <= {8'h0C, 16'h7D01};
        try(14'h0004, 16'hFF85, 3'h1, 8'h20);
        @(posedge clock_in) {exp_mag, digits} <= {16'h7D00, 10'h100};
        try(14'h0004, 16'hFF84, 3'h1, 8'h20);
        u_isr_host_model.request(RD_CTRL);
        try(14'h0000, 16'hFE5C, 3'h4, 8'h04);
        fire(14'h0200);
        check(skip, 1'b1);
        try(14'h0000, 16'hFE52, 3'h4, 8'h04);
        fire(14'h0400);
        check(skip, 1'b0);
        $display("test codes done");
        // Summary bits, service request and serial poll
        @(posedge clock_in) sre_data <= 8'hFF;
        fire(14'h3000);
        check(sre_q, 8'hBF);
        fire(14'h0010);
        check(stb, 8'h44);
        check(srq, 1'b1);
        @(posedge clock_in) ese_data <= 8'h10;
        fire(14'h2000);
        check(ese_q, 8'h10);
        check(stb, 8'h64);
        @(posedge clock_in) pending <= 1'b1;
        fire(14'h0000);
        check(stb, 8'h74);
        u_isr_host_model.request(RD_CTRL);
        u_isr_host_model.request(POLL);
        check(poll_byte, 8'h74);
        fire(14'h0000);
        check(srq, 1'b0);
        check(stb, 8'h74);
        @(posedge clock_in) pending <= 1'b0;
        u_isr_host_model.request(RD_ESR);
        check(esr_q, 8'h10);
        try(14'h0000, 16'hFF23, 3'h2, 8'h00);
        fire(14'h0000);
        check(stb, 8'h00);
        $display("test service_request done");
        // Overflow: oldest first, ninth normal code, then the overflow code
        fire(14'h0080);
        for (i = 0; i < 10; i = i + 1)
            fire(14'h0008);
        try(14'h0000, 16'hFEB6, 3'h3, 8'h18);
        for (i = 0; i < 8; i = i + 1)
            try(14'h0000, 16'hFF2D, 3'h2, 8'h00);
        try(14'h0000, 16'hFEA2, 3'h3, 8'h00);
        try(14'h0000, 16'h0000, 3'h0, 8'h00);
        fire(14'h0008);
        fire(14'h0800);
        try(14'h0000, 16'h0000, 3'h0, 8'h00);
        check(ese_q, 8'h10);
        $display("test queue done");
        end_sim;
    end
endmodule // tb_top
